// File: common/usb_event_pkg.sv
// Purpose: Constants for the USB device event flag block
// Assumes: 40 MHz system clock, 32-bit APB
// Notes:   Offsets are byte addresses
`default_nettype none
package usb_event_pkg;
  localparam logic [11:0] OFF_FLAGS  = 12'h000;
  localparam logic [11:0] OFF_MASK   = 12'h004;
  localparam logic [11:0] OFF_ERREN  = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_HOSTMD = 12'h010;
  localparam logic [11:0] OFF_TOKSTS = 12'h014;

  localparam int BIT_RESET  = 0;
  localparam int BIT_ERROR  = 1;
  localparam int BIT_FRAME  = 2;
  localparam int BIT_TOKEN  = 3;
  localparam int BIT_IDLE   = 4;
  localparam int BIT_RESUME = 5;
  localparam int BIT_STALL  = 7;

  localparam int          FLAG_W       = 16;
  localparam logic [15:0] FLAG_IMPL    = 16'h00bf;
  localparam logic [15:0] FLAG_RESET   = 16'h0000;
  localparam int          ERR_W        = 8;
  localparam int          TOK_W        = 8;

  localparam int CLK_HZ         = 40000000;
  localparam int RESUME_NS      = 2500;
  localparam int RESET_NS       = 2500;
  localparam int IDLE_US        = 3000;
  localparam int RESUME_CYC     = (RESUME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int RESET_CYC      = (RESET_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int IDLE_CYC       = IDLE_US * (CLK_HZ / 1000000);

  typedef enum logic [1:0] {
    LINE_SE0,
    LINE_J,
    LINE_K,
    LINE_SE1
  } line_state_t;
endpackage : usb_event_pkg
`default_nettype wire

// File: hdl/token_fifo.sv
// Purpose: Small token status FIFO with registered read data
// Assumes: Single clock, writes dropped when full unless a pop is taken in the same cycle
// Notes:   Head word is always presented on rd_data_out
`default_nettype none
module token_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_n_in,
  input  wire logic             wr_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             pop_in,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  empty_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  logic             do_wr;
  logic             do_pop;
  logic [AW-1:0]    rptr_next;

  assign do_pop    = pop_in && (count_reg != '0);
  assign do_wr     = wr_in && ((count_reg != (AW+1)'(DEPTH)) || do_pop);
  assign rptr_next = do_pop ? rptr_reg + 1'b1 : rptr_reg;

  always_ff @(posedge clk_sys_in) begin
    if (do_wr) begin
      mem_reg[wptr_reg] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      rptr_reg  <= rptr_next;
      count_reg <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_pop);
    end
  end

  // Read register; bypass when writing into the empty head slot
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_out <= '0;
      empty_out   <= 1'b1;
    end else begin
      if (do_wr && (wptr_reg == rptr_next)) begin
        rd_data_out <= wr_data_in;
      end else begin
        rd_data_out <= mem_reg[rptr_next];
      end
      empty_out <= ((count_reg + (AW+1)'(do_wr) - (AW+1)'(do_pop)) == '0);
    end
  end
endmodule : token_fifo
`default_nettype wire

// File: hdl/usb_device_event_flags.sv
// Purpose: USB device event flag register with APB access and interrupt
// Assumes: Line state and engine events synchronous to clk_sys_in
// Notes:   Flag clear is write-one in a full-word APB write
`default_nettype none
module usb_device_event_flags
  import usb_event_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_CYC,
  parameter int FIFO_DEPTH  = 4
) (
  input  wire logic              clk_sys_in,
  input  wire logic              reset_n_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [11:0]       paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic [1:0]        line_state_in,
  input  wire logic              low_speed_in,
  input  wire logic              stall_sent_in,
  input  wire logic              token_done_in,
  input  wire logic [TOK_W-1:0]  token_status_in,
  input  wire logic              sof_token_in,
  input  wire logic              sof_threshold_in,
  input  wire logic [ERR_W-1:0]  error_in,
  output logic                   irq_out
);
  logic [FLAG_W-1:0] flags_reg;
  logic [FLAG_W-1:0] flags_next;
  logic [FLAG_W-1:0] mask_reg;
  logic [ERR_W-1:0]  err_enable_reg;
  logic              host_mode_reg;
  logic [FLAG_W-1:0] set_vec;
  logic [FLAG_W-1:0] clr_vec;
  logic              access;
  logic              wr_flags;
  logic [31:0]       rdata_next;
  logic              err_next;
  logic              k_state;
  logic              idle_state;
  logic              se0_state;
  logic [15:0]       resume_cnt_reg;
  logic [15:0]       reset_cnt_reg;
  logic [31:0]       idle_cnt_reg;
  logic              resume_done_reg;
  logic              reset_done_reg;
  logic              idle_done_reg;
  logic              resume_hit;
  logic              reset_hit;
  logic              idle_hit;
  logic              fifo_pop;
  logic [TOK_W-1:0]  tok_head;
  logic              tok_empty;

  assign access   = psel_in && penable_in;
  assign wr_flags = access && pwrite_in && (paddr_in == OFF_FLAGS);

  // Full speed K is differential zero, low speed K is differential one
  assign k_state    = low_speed_in ? (line_state_in == LINE_J) :
                                     (line_state_in == LINE_K);
  // Idle (J) is the inverse polarity of K
  assign idle_state = low_speed_in ? (line_state_in == LINE_K) :
                                     (line_state_in == LINE_J);
  assign se0_state  = (line_state_in == LINE_SE0);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      resume_cnt_reg  <= '0;
      resume_done_reg <= 1'b0;
    end else if (!k_state) begin
      resume_cnt_reg  <= '0;
      resume_done_reg <= 1'b0;
    end else if (!resume_done_reg) begin
      if (resume_cnt_reg == 16'(RESUME_CYC - 1)) begin
        resume_done_reg <= 1'b1;
      end
      resume_cnt_reg <= resume_cnt_reg + 16'h0001;
    end
  end
  assign resume_hit = k_state && !resume_done_reg &&
                      (resume_cnt_reg == 16'(RESUME_CYC - 1));

  // Reset fires once per SE0 episode
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reset_cnt_reg  <= '0;
      reset_done_reg <= 1'b0;
    end else if (!se0_state) begin
      reset_cnt_reg  <= '0;
      reset_done_reg <= 1'b0;
    end else if (!reset_done_reg) begin
      if (reset_cnt_reg == 16'(RESET_CYC - 1)) begin
        reset_done_reg <= 1'b1;
      end
      reset_cnt_reg <= reset_cnt_reg + 16'h0001;
    end
  end
  assign reset_hit = se0_state && !reset_done_reg &&
                     (reset_cnt_reg == 16'(RESET_CYC - 1));

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      idle_cnt_reg  <= '0;
      idle_done_reg <= 1'b0;
    end else if (!idle_state) begin
      idle_cnt_reg  <= '0;
      idle_done_reg <= 1'b0;
    end else if (!idle_done_reg) begin
      if (idle_cnt_reg == 32'(IDLE_CYCLES - 1)) begin
        idle_done_reg <= 1'b1;
      end
      idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
    end
  end
  assign idle_hit = idle_state && !idle_done_reg &&
                    (idle_cnt_reg == 32'(IDLE_CYCLES - 1));

  assign err_next = |(error_in & err_enable_reg);

  always_comb begin
    set_vec              = '0;
    set_vec[BIT_STALL]   = stall_sent_in;
    set_vec[BIT_RESUME]  = resume_hit;
    set_vec[BIT_IDLE]    = idle_hit;
    set_vec[BIT_TOKEN]   = token_done_in;
    set_vec[BIT_FRAME]   = sof_token_in || (host_mode_reg && sof_threshold_in);
    set_vec[BIT_ERROR]   = err_next;
    set_vec[BIT_RESET]   = reset_hit;
    clr_vec = wr_flags ? pwdata_in[FLAG_W-1:0] : '0;
    // Set beats clear so a coincident event is kept
    flags_next = ((flags_reg & ~clr_vec) | set_vec) & FLAG_IMPL;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_reg <= FLAG_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Advance only when a set token flag is actually cleared
  assign fifo_pop = wr_flags && pwdata_in[BIT_TOKEN] && flags_reg[BIT_TOKEN];

  token_fifo #(
    .WIDTH (TOK_W),
    .DEPTH (FIFO_DEPTH)
  ) u_token_fifo (
    .clk_sys_in  (clk_sys_in),
    .reset_n_in  (reset_n_in),
    .wr_in       (token_done_in),
    .wr_data_in  (token_status_in),
    .pop_in      (fifo_pop),
    .rd_data_out (tok_head),
    .empty_out   (tok_empty)
  );

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask_reg       <= '0;
      err_enable_reg <= '0;
      host_mode_reg  <= 1'b0;
    end else if (access && pwrite_in) begin
      if (paddr_in == OFF_MASK) begin
        mask_reg <= pwdata_in[FLAG_W-1:0] & FLAG_IMPL;
      end else if (paddr_in == OFF_ERREN) begin
        err_enable_reg <= pwdata_in[ERR_W-1:0];
      end else if (paddr_in == OFF_HOSTMD) begin
        host_mode_reg <= pwdata_in[0];
      end
    end
  end

  always_comb begin
    rdata_next = '0;
    if (paddr_in == OFF_FLAGS) begin
      rdata_next[FLAG_W-1:0] = flags_reg;
    end else if (paddr_in == OFF_MASK) begin
      rdata_next[FLAG_W-1:0] = mask_reg;
    end else if (paddr_in == OFF_ERREN) begin
      rdata_next[ERR_W-1:0] = err_enable_reg;
    end else if (paddr_in == OFF_STATUS) begin
      rdata_next[FLAG_W-1:0] = flags_reg & mask_reg;
    end else if (paddr_in == OFF_HOSTMD) begin
      rdata_next[0] = host_mode_reg;
    end else if (paddr_in == OFF_TOKSTS) begin
      rdata_next[TOK_W-1:0] = tok_head;
      rdata_next[TOK_W]     = tok_empty;
    end
  end

  // Zero-wait slave: pready is registered high in the access phase
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out  <= '0;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      prdata_out  <= (psel_in && !penable_in && !pwrite_in) ? rdata_next : '0;
      pslverr_out <= psel_in && !penable_in &&
                     (paddr_in[1:0] != 2'b00 || paddr_in > OFF_TOKSTS);
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(flags_next & mask_reg);
    end
  end

  a_stall_set: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    stall_sent_in |=> flags_reg[BIT_STALL])
    else $error("stall flag not set");

  sequence s_k_held;
    k_state [*8];
  endsequence
  a_resume_late: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(resume_hit) |-> $past(resume_cnt_reg) == 16'(RESUME_CYC - 2))
    else $error("resume timing wrong");
  a_resume_early: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(k_state) ##0 s_k_held |-> !flags_reg[BIT_RESUME] || $past(flags_reg[BIT_RESUME], 8))
    else $error("resume set too early");

  a_idle_set: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    idle_hit |-> idle_cnt_reg == 32'(IDLE_CYCLES - 1) ##1 flags_reg[BIT_IDLE])
    else $error("idle flag timing wrong");

  a_token_set: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    token_done_in |=> flags_reg[BIT_TOKEN] && !tok_empty)
    else $error("token flag or fifo missing");

  a_token_pop: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    fifo_pop |-> u_token_fifo.count_reg != '0 ##1
      u_token_fifo.count_reg == $past(u_token_fifo.count_reg) - 1'b1 + $past(token_done_in))
    else $error("fifo did not advance");

  a_frame_set: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    sof_token_in |=> flags_reg[BIT_FRAME])
    else $error("frame flag not set");

  a_frame_host: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    host_mode_reg && sof_threshold_in |=> flags_reg[BIT_FRAME])
    else $error("host threshold frame flag missing");

  a_error_mask: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(flags_reg[BIT_ERROR]) |-> $past(|(error_in & err_enable_reg)))
    else $error("error flag set by masked error");

  a_reset_once: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    reset_done_reg && se0_state |=> !$rose(flags_reg[BIT_RESET]))
    else $error("bus reset flag retriggered");

  a_reset_len: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(flags_reg[BIT_RESET]) |->
      $past(se0_state) && $past(reset_cnt_reg) == 16'(RESET_CYC - 1))
    else $error("bus reset too short");

  a_w1c_clear: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    wr_flags && pwdata_in[BIT_STALL] && !stall_sent_in |=> !flags_reg[BIT_STALL])
    else $error("write one did not clear");

  a_w0_keep: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    wr_flags && !pwdata_in[BIT_IDLE] && flags_reg[BIT_IDLE] |=> flags_reg[BIT_IDLE])
    else $error("write zero cleared a flag");

  a_unimpl_zero: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (flags_reg & ~FLAG_IMPL) == '0)
    else $error("unimplemented bit set");

  // Catches a flag rising with no event behind it
  a_flag_cause: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    ((flags_reg & ~$past(flags_reg)) & ~$past(set_vec)) == '0)
    else $error("flag set without event");

  a_set_wins: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    wr_flags && pwdata_in[BIT_TOKEN] && token_done_in |=> flags_reg[BIT_TOKEN])
    else $error("event lost on clear");
endmodule : usb_device_event_flags
`default_nettype wire

// File: tb/usb_host_model.sv
// Purpose: Far-side model of the USB engine events and bus line state
// Assumes: Tasks are entered just after a rising edge of clk_sys_in
// Notes:   Line parks at SE1 so idle, resume and reset timers stay quiet
`default_nettype none
module usb_host_model
  import usb_event_pkg::*;
(
  input  wire logic             clk_sys_in,
  output logic      [1:0]       line_state_out,
  output logic                  low_speed_out,
  output logic                  stall_sent_out,
  output logic                  token_done_out,
  output logic      [TOK_W-1:0] token_status_out,
  output logic                  sof_token_out,
  output logic                  sof_threshold_out,
  output logic      [ERR_W-1:0] error_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    line_state_out = LINE_SE1;
    low_speed_out = 1'b0;
    {sof_threshold_out, sof_token_out, token_done_out, stall_sent_out} = 4'h0;
    token_status_out = 8'h5a;
    error_out = '0;
  end

  // Line level persists until changed; caller times the hold
  task automatic drive_line(input logic [1:0] st);
    line_state_out <= st;
  endtask : drive_line

  task automatic set_speed(input logic s);
    low_speed_out <= s;
  endtask : set_speed

  // One-cycle pulses: ev = {threshold, sof, token, stall}
  task automatic events(input logic [3:0] ev, input logic [TOK_W-1:0] tok,
                        input logic [ERR_W-1:0] err);
    {sof_threshold_out, sof_token_out, token_done_out, stall_sent_out} <= ev;
    token_status_out <= tok;
    error_out <= err;
    @(posedge clk_sys_in);
    {sof_threshold_out, sof_token_out, token_done_out, stall_sent_out} <= 4'h0;
    // Status is not held after the push
    token_status_out <= ~tok;
    error_out <= '0;
    @(posedge clk_sys_in);
  endtask : events
endmodule : usb_host_model
`default_nettype wire

// File: tb/usb_device_event_flags_tb.sv
// Purpose: Self-checking bench for the USB device event flag block
// Assumes: APB answers by pready; idle count shortened by parameter
// Notes:   Line is parked at SE1 outside the timer scenarios
`default_nettype none
module usb_device_event_flags_tb
  import usb_event_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IDLE_SIM = 50;
  logic              clk_sys_in = 1'b0;
  logic              reset_n_in = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic [1:0]        line;
  logic              low_speed;
  logic              stall;
  logic              tok_done;
  logic [TOK_W-1:0]  tok_sts;
  logic              sof;
  logic              sof_thr;
  logic [ERR_W-1:0]  err;
  logic [31:0]       rdata;
  logic              rerr;
  int                bad_count = 0;
  int                samples_checked = 0;
  int                cyc = 0;

  always #12.5 clk_sys_in = ~clk_sys_in;

  usb_device_event_flags #(.IDLE_CYCLES(IDLE_SIM), .FIFO_DEPTH(4)) uut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .line_state_in(line), .low_speed_in(low_speed), .stall_sent_in(stall),
    .token_done_in(tok_done), .token_status_in(tok_sts), .sof_token_in(sof),
    .sof_threshold_in(sof_thr), .error_in(err), .irq_out(irq));

  usb_host_model host (
    .clk_sys_in(clk_sys_in), .line_state_out(line), .low_speed_out(low_speed),
    .stall_sent_out(stall), .token_done_out(tok_done), .token_status_out(tok_sts),
    .sof_token_out(sof), .sof_threshold_out(sof_thr), .error_out(err));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) bad_count++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_in);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, exp, rdata);
  endtask : rd

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict;
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    rd(OFF_FLAGS, 32'h0, "flags at reset");
    rd(OFF_TOKSTS, 32'h100, "fifo empty at reset");
    chk("irq at reset", 32'h0, {31'h0, irq});
    wr(OFF_MASK, 32'h0000_00bf);
    host.events(4'b0001, 8'h00, 8'h00);
    rd(OFF_FLAGS, 32'h80, "stall flag");
    chk("irq on stall", 32'h1, {31'h0, irq});
    wr(OFF_FLAGS, 32'h0);
    rd(OFF_FLAGS, 32'h80, "zero write keeps");
    // Event lands on the very edge that applies the clear
    fork
      wr(OFF_FLAGS, 32'h80);
      begin
        @(posedge clk_sys_in);
        host.events(4'b0001, 8'h00, 8'h00);
      end
    join
    rd(OFF_FLAGS, 32'h80, "set beats clear");
    wr(OFF_FLAGS, 32'hffff_ffff);
    rd(OFF_FLAGS, 32'h0, "all flags cleared");
    chk("irq after clear", 32'h0, {31'h0, irq});
    host.events(4'b1000, 8'h00, 8'h00);
    rd(OFF_FLAGS, 32'h0, "threshold ignored");
    wr(OFF_HOSTMD, 32'h1);
    for (int i = 0; i < 2; i++) begin
      host.events(i == 0 ? 4'b0100 : 4'b1000, 8'h00, 8'h00);
      rd(OFF_FLAGS, 32'h04, "frame start flag");
      wr(OFF_FLAGS, 32'h04);
    end
    wr(OFF_ERREN, 32'h01);
    host.events(4'b0000, 8'h00, 8'h02);
    rd(OFF_FLAGS, 32'h0, "disabled error");
    host.events(4'b0000, 8'h00, 8'h01);
    rd(OFF_FLAGS, 32'h02, "enabled error");
    wr(OFF_FLAGS, 32'h02);
    host.events(4'b0010, 8'ha1, 8'h00);
    host.events(4'b0010, 8'hb2, 8'h00);
    rd(OFF_FLAGS, 32'h08, "token done flag");
    rd(OFF_TOKSTS, 32'h0a1, "fifo head first");
    wr(OFF_FLAGS, 32'h08);
    rd(OFF_TOKSTS, 32'h0b2, "fifo advanced");
    // Flag already clear: a second clear must not pop
    wr(OFF_FLAGS, 32'h08);
    rd(OFF_TOKSTS, 32'h0b2, "no pop when clear");
    host.events(4'b0001, 8'h00, 8'h00);
    wr(OFF_MASK, 32'h0);
    rd(OFF_STATUS, 32'h0, "masked status");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFF_MASK, 32'h80);
    rd(OFF_STATUS, 32'h80, "unmasked status");
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(OFF_FLAGS, 32'h80);
    for (int sp = 0; sp < 2; sp++) begin
      host.set_speed(sp[0]);
      host.drive_line(sp == 0 ? LINE_K : LINE_J);
      repeat (RESUME_CYC - 10) @(posedge clk_sys_in);
      host.drive_line(LINE_SE1);
      rd(OFF_FLAGS, 32'h0, "short resume");
      host.drive_line(sp == 0 ? LINE_K : LINE_J);
      repeat (RESUME_CYC + 5) @(posedge clk_sys_in);
      host.drive_line(LINE_SE1);
      rd(OFF_FLAGS, 32'h20, "resume flag");
      wr(OFF_FLAGS, 32'h20);
    end
    host.set_speed(1'b0);
    host.drive_line(LINE_J);
    repeat (IDLE_SIM - 15) @(posedge clk_sys_in);
    rd(OFF_FLAGS, 32'h0, "idle too short");
    repeat (20) @(posedge clk_sys_in);
    rd(OFF_FLAGS, 32'h10, "idle flag");
    host.drive_line(LINE_SE1);
    wr(OFF_FLAGS, 32'h10);
    host.drive_line(LINE_SE0);
    repeat (RESET_CYC + 10) @(posedge clk_sys_in);
    rd(OFF_FLAGS, 32'h01, "bus reset flag");
    wr(OFF_FLAGS, 32'h01);
    repeat (150) @(posedge clk_sys_in);
    rd(OFF_FLAGS, 32'h0, "reset not re-flagged");
    host.drive_line(LINE_SE1);
    repeat (2) @(posedge clk_sys_in);
    host.drive_line(LINE_SE0);
    repeat (RESET_CYC + 10) @(posedge clk_sys_in);
    host.drive_line(LINE_SE1);
    rd(OFF_FLAGS, 32'h01, "second bus reset");
    wr(OFF_FLAGS, 32'h01);
    for (int i = 0; i < 2; i++) begin
      xfer(1'b0, i == 0 ? 12'h018 : 12'h002, 32'h0);
      chk("error response", 32'h1, {31'h0, rerr});
    end
    give_verdict;
  end
endmodule : usb_device_event_flags_tb
`default_nettype wire
